// ### include/sfpf_map.svh
// constants of the serial flash pin front end
`ifndef SFPF_MAP_SVH
`define SFPF_MAP_SVH
`define SFPF_ADDR_W 24
`define SFPF_SECT_HI 19
`define SFPF_SECT_LO 12
`define SFPF_BLK32_LO 15
`define SFPF_BLK64_LO 16
`define SFPF_SECT_W 8
`define SFPF_BLK32_W 5
`define SFPF_BLK64_W 4
`define SFPF_CNT_W 6
`endif

// ### include/sfpf_pkg.sv
// types of the serial flash pin front end
package sfpf_pkg;
   typedef enum logic [2:0] {
      SFPF_SINGLE = 3'h1,
      SFPF_DUAL = 3'h2,
      SFPF_QUAD = 3'h4
   } sfpf_width_e;
   typedef enum logic [2:0] {
      SFPF_IDLE = 3'h1,
      SFPF_SHIFT = 3'h2,
      SFPF_PAUSED = 3'h4
   } sfpf_state_e;
endpackage

// ### design/sfpf_addr_decode.sv
// sector and block index decode of a byte address
`include "sfpf_map.svh"
`default_nettype none
module sfpf_addr_decode (
   // address in
   input wire logic [`SFPF_ADDR_W-1:0] byteAddr,
   // indices out
   output logic [`SFPF_SECT_W-1:0] sectorIdx,
   output logic [`SFPF_BLK32_W-1:0] block32Idx,
   output logic [`SFPF_BLK64_W-1:0] block64Idx
);
   // blocks are size aligned, so a block is a run of sectors
   assign sectorIdx = byteAddr[`SFPF_SECT_HI:`SFPF_SECT_LO];
   assign block32Idx = byteAddr[`SFPF_SECT_HI:`SFPF_BLK32_LO];
   assign block64Idx = byteAddr[`SFPF_SECT_HI:`SFPF_BLK64_LO];
endmodule // sfpf_addr_decode
`default_nettype wire

// ### design/sfpf_front_end.sv
// pin front end of a serial flash: clocking, pin reuse, pause, reset
// Contract
// - quad enable turns pin three into data line 2
// - quad enable makes pin four data line 3 only
// - pin four pause or reset by select bit
// - pause freezes the sequence, keeps received bits
// - paused and selected: output off, resume after
// - reset input low: reset mode, output off
// - accept clock parked low or high
// - sample on rising, launch on falling edge
// - dual mode: lines 0 and 1 bidirectional
// - quad mode: four pins are data lines
// - array in 4 Kbyte sectors, 32/64 Kbyte blocks
// - blocks are eight/sixteen aligned sectors
// - deselected: ignore input, outputs off
`include "sfpf_map.svh"
`default_nettype none
module sfpf_front_end #(
   parameter int UNIT_W = 8
) (
   // system
   input wire logic sys_clk,
   input wire logic rstn,
   // link pins
   input wire logic chipSelN,
   input wire logic serialClk,
   input wire logic dataLine0In,
   output logic dataLine0Out,
   output logic dataLine0Oe,
   input wire logic dataLine1In,
   output logic dataLine1Out,
   output logic dataLine1Oe,
   input wire logic dataLine2In,
   output logic dataLine2Out,
   output logic dataLine2Oe,
   input wire logic dataLine3In,
   output logic dataLine3Out,
   output logic dataLine3Oe,
   // configuration
   input wire logic quadEnableBit,
   input wire logic pinFunctionSelect,
   input wire logic quadCommandMode,
   input wire sfpf_pkg::sfpf_width_e busWidth,
   input wire logic driveDir,
   // core side
   input wire logic [UNIT_W-1:0] txUnit,
   output logic txTaken,
   output logic [UNIT_W-1:0] rxUnit,
   output logic rxValid,
   output logic writeProtectN,
   output logic selected,
   output logic paused,
   output logic inReset,
   input wire logic [`SFPF_ADDR_W-1:0] byteAddr,
   output logic [`SFPF_SECT_W-1:0] sectorIdx,
   output logic [`SFPF_BLK32_W-1:0] block32Idx,
   output logic [`SFPF_BLK64_W-1:0] block64Idx
);
   initial begin
      if (UNIT_W != 8) $error("unit width must be 8");
   end

   logic rstMeta_ff, rstSync_ff;
   logic [1:0] csS_ff, clkS_ff, d0S_ff, d1S_ff, d2S_ff, d3S_ff;
   logic clkPrev_ff;
   logic [UNIT_W-1:0] shift_ff, txShift_ff;
   logic [`SFPF_CNT_W-1:0] bitCnt_ff;
   logic [UNIT_W-1:0] rxUnit_ff;
   logic rxValid_ff, txTaken_ff;
   logic [3:0] outBits_ff;
   logic outOn_ff;
   logic pinPaused_ff;
   sfpf_pkg::sfpf_state_e state_ff;

   always_ff @(posedge sys_clk or negedge rstn) begin
      if (!rstn) begin
         rstMeta_ff <= 1'b0;
         rstSync_ff <= 1'b0;
      end else begin
         rstMeta_ff <= 1'b1;
         rstSync_ff <= rstMeta_ff;
      end
   end
   wire logic rstSyncN = rstSync_ff;

   // pins come from the master's domain: two flops each
   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         csS_ff <= 2'h3;
         clkS_ff <= 2'h0;
         d0S_ff <= 2'h0;
         d1S_ff <= 2'h0;
         d2S_ff <= 2'h3;
         d3S_ff <= 2'h3;
         clkPrev_ff <= 1'b0;
      end else begin
         csS_ff <= {csS_ff[0], chipSelN};
         clkS_ff <= {clkS_ff[0], serialClk};
         d0S_ff <= {d0S_ff[0], dataLine0In};
         d1S_ff <= {d1S_ff[0], dataLine1In};
         d2S_ff <= {d2S_ff[0], dataLine2In};
         d3S_ff <= {d3S_ff[0], dataLine3In};
         clkPrev_ff <= clkS_ff[1];
      end
   end

   wire logic csN = csS_ff[1];
   wire logic d3Pin = d3S_ff[1];
   // pin four functions only exist without quad enable
   wire logic holdFunc = !quadEnableBit && !pinFunctionSelect;
   wire logic rstFunc = !quadEnableBit && pinFunctionSelect;
   wire logic quadLines = quadEnableBit || quadCommandMode;
   wire logic hwReset = rstFunc && !d3Pin;
   wire logic holdNow = holdFunc && !d3Pin && !csN;
   // edge detect on the second flop only; the clock idle level is free
   wire logic riseEdge = clkS_ff[1] && !clkPrev_ff;
   wire logic fallEdge = !clkS_ff[1] && clkPrev_ff;
   wire logic active = !csN && !hwReset && !holdNow;

   logic [`SFPF_CNT_W-1:0] step;
   always_comb begin
      case (busWidth)
         sfpf_pkg::SFPF_DUAL: step = `SFPF_CNT_W'h2;
         sfpf_pkg::SFPF_QUAD: step = quadLines ? `SFPF_CNT_W'h4
                                              : `SFPF_CNT_W'h1;
         default: step = `SFPF_CNT_W'h1;
      endcase
   end

   // state: a pause freezes without clearing, a deselect or reset clears
   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         state_ff <= sfpf_pkg::SFPF_IDLE;
      end else if (csN || hwReset) begin
         state_ff <= sfpf_pkg::SFPF_IDLE;
      end else begin
         case (state_ff)
            sfpf_pkg::SFPF_IDLE:
               state_ff <= holdNow ? sfpf_pkg::SFPF_PAUSED
                                   : sfpf_pkg::SFPF_SHIFT;
            sfpf_pkg::SFPF_SHIFT:
               if (holdNow) state_ff <= sfpf_pkg::SFPF_PAUSED;
            sfpf_pkg::SFPF_PAUSED:
               if (!holdNow) state_ff <= sfpf_pkg::SFPF_SHIFT;
            default: state_ff <= sfpf_pkg::SFPF_IDLE;
         endcase
      end
   end

   // receive on rising edges
   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         shift_ff <= '0;
         bitCnt_ff <= '0;
         rxUnit_ff <= '0;
         rxValid_ff <= 1'b0;
      end else begin
         rxValid_ff <= 1'b0;
         if (csN || hwReset) begin
            bitCnt_ff <= '0;
         end else if (active && riseEdge && !driveDir) begin
            case (step)
               `SFPF_CNT_W'h2:
                  shift_ff <= {shift_ff[UNIT_W-3:0], d1S_ff[1],
                     d0S_ff[1]};
               `SFPF_CNT_W'h4:
                  shift_ff <= {shift_ff[UNIT_W-5:0], d3Pin, d2S_ff[1],
                     d1S_ff[1], d0S_ff[1]};
               default:
                  shift_ff <= {shift_ff[UNIT_W-2:0], d0S_ff[1]};
            endcase
            if (bitCnt_ff + step >= `SFPF_CNT_W'(UNIT_W)) begin
               bitCnt_ff <= '0;
               rxValid_ff <= 1'b1;
               case (step)
                  `SFPF_CNT_W'h2: rxUnit_ff <= {shift_ff[UNIT_W-3:0],
                     d1S_ff[1], d0S_ff[1]};
                  `SFPF_CNT_W'h4: rxUnit_ff <= {shift_ff[UNIT_W-5:0],
                     d3Pin, d2S_ff[1], d1S_ff[1], d0S_ff[1]};
                  default: rxUnit_ff <= {shift_ff[UNIT_W-2:0],
                     d0S_ff[1]};
               endcase
            end else begin
               bitCnt_ff <= bitCnt_ff + step;
            end
         end
      end
   end

   // transmit launched on falling edges, unit taken on first edge
   logic [`SFPF_CNT_W-1:0] txCnt_ff;
   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         txShift_ff <= '0;
         txCnt_ff <= '0;
         outBits_ff <= 4'h0;
         txTaken_ff <= 1'b0;
      end else begin
         txTaken_ff <= 1'b0;
         if (csN || hwReset) begin
            txCnt_ff <= '0;
         end else if (active && fallEdge && driveDir) begin
            logic [UNIT_W-1:0] src;
            src = (txCnt_ff == '0) ? txUnit : txShift_ff;
            txTaken_ff <= (txCnt_ff == '0);
            case (step)
               `SFPF_CNT_W'h2: outBits_ff <= {2'h0, src[UNIT_W-1 -: 2]};
               `SFPF_CNT_W'h4: outBits_ff <= src[UNIT_W-1 -: 4];
               default: outBits_ff <= {2'h0, src[UNIT_W-1], 1'b0};
            endcase
            txShift_ff <= src << step;
            txCnt_ff <= (txCnt_ff + step >= `SFPF_CNT_W'(UNIT_W)) ? '0
                        : txCnt_ff + step;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         outOn_ff <= 1'b0;
         pinPaused_ff <= 1'b0;
      end else begin
         // off while deselected, paused or in reset
         outOn_ff <= active && driveDir;
         pinPaused_ff <= holdNow;
      end
   end

   // the flop lags a deselect by a cycle, so gate it with the live level
   wire logic outOn = outOn_ff && active;
   wire logic quadOut = outOn && step == `SFPF_CNT_W'h4;
   wire logic wideOut = outOn && step != `SFPF_CNT_W'h1;
   assign dataLine0Out = outBits_ff[0];
   assign dataLine0Oe = wideOut;
   assign dataLine1Out = outBits_ff[1];
   assign dataLine1Oe = outOn;
   assign dataLine2Out = outBits_ff[2];
   assign dataLine2Oe = quadOut;
   assign dataLine3Out = outBits_ff[3];
   assign dataLine3Oe = quadOut;
   // protect input ignored while the quad enable bit is set
   assign writeProtectN = quadEnableBit ? 1'b1 : d2S_ff[1];
   assign rxUnit = rxUnit_ff;
   assign rxValid = rxValid_ff;
   assign txTaken = txTaken_ff;
   assign selected = !csN;
   assign paused = pinPaused_ff;
   assign inReset = hwReset;

   sfpf_addr_decode u_decode (
      .byteAddr(byteAddr),
      .sectorIdx(sectorIdx),
      .block32Idx(block32Idx),
      .block64Idx(block64Idx)
   );
endmodule // sfpf_front_end
`default_nettype wire

// ### test/sfpf_front_end_sva.sv
// assertions at the pins of the flash front end
`include "sfpf_map.svh"
`default_nettype none
module sfpf_front_end_sva (
   // system
   input wire logic sys_clk,
   input wire logic rstn,
   // pins
   input wire logic dataLine0Oe, dataLine1Oe, dataLine2Oe, dataLine3Oe,
   input wire logic dataLine3In,
   // configuration and status
   input wire logic quadEnableBit, pinFunctionSelect,
   input wire logic writeProtectN, selected, paused, inReset,
   // address decode
   input wire logic [`SFPF_ADDR_W-1:0] byteAddr,
   input wire logic [`SFPF_SECT_W-1:0] sectorIdx,
   input wire logic [`SFPF_BLK32_W-1:0] block32Idx,
   input wire logic [`SFPF_BLK64_W-1:0] block64Idx
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   wire logic anyOe = dataLine0Oe | dataLine1Oe | dataLine2Oe | dataLine3Oe;
   wire logic pin4Low = !quadEnableBit && !dataLine3In;
   // five cycles cover the pin synchronisers
   sequence s_rstReq; (pin4Low && pinFunctionSelect) [*5]; endsequence
   sequence s_holdReq; (pin4Low && !pinFunctionSelect && selected) [*5];
   endsequence
   property p_desel; !selected |-> !anyOe; endproperty
   property p_pause; paused |-> !dataLine1Oe; endproperty
   property p_rst; inReset |-> !anyOe; endproperty
   property p_wp; quadEnableBit [*2] |-> writeProtectN; endproperty
   property p_qe; quadEnableBit [*4] |-> !inReset && !paused; endproperty
   property p_pinrst; s_rstReq |-> inReset; endproperty
   property p_hold; s_holdReq |-> paused; endproperty
   property p_sect; sectorIdx == byteAddr[19:12]; endproperty
   property p_blk;
      block32Idx == sectorIdx[7:3] && block64Idx == sectorIdx[7:4];
   endproperty
   a_desel: assert property (p_desel) else $error("drive deselected");
   a_pause: assert property (p_pause) else $error("drive paused");
   a_rst: assert property (p_rst) else $error("drive in reset");
   a_wp: assert property (p_wp) else $error("protect with quad");
   a_qe: assert property (p_qe) else $error("pin four func");
   a_pinrst: assert property (p_pinrst) else $error("no reset");
   a_hold: assert property (p_hold) else $error("no pause");
   a_sect: assert property (p_sect) else $error("sector index");
   a_blk: assert property (p_blk) else $error("block index");
endmodule // sfpf_front_end_sva
`default_nettype wire

// ### test/sfpf_spi_master.sv
// spi master model feeding frames to the flash front end
`default_nettype none
module sfpf_spi_master (
   // system
   input wire logic sys_clk,
   // link
   output logic chipSelN = 1'h1,
   output logic serialClk = 1'h0,
   output logic dataOut = 1'h0
);
   timeunit 1ns;
   timeprecision 1ns;
   logic idleLvl = 1'h0;
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge sys_clk);
   endtask
   task automatic open_frame(input logic mode3);
      idleLvl = mode3;
      serialClk <= mode3;
      wait_cyc(4);
      chipSelN <= 1'h0;
      wait_cyc(4);
   endtask
   // half period of four cycles gives 80 ns
   task automatic put_bits(input logic [3:0] val);
      for (int i = 3; i >= 0; i--) begin
         serialClk <= 1'h0;
         dataOut <= val[i];
         wait_cyc(4);
         serialClk <= 1'h1;
         wait_cyc(4);
      end
   endtask
   task automatic close_frame();
      serialClk <= idleLvl;
      wait_cyc(4);
      chipSelN <= 1'h1;
      // released line must not keep the last bit
      dataOut <= ~dataOut;
      wait_cyc(4);
   endtask
endmodule // sfpf_spi_master
`default_nettype wire

// ### test/sfpf_front_end_tb.sv
// bench of the serial flash pin front end
`include "sfpf_map.svh"
`default_nettype none
module sfpf_front_end_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'h0, rstn, chipSelN, serialClk, mData0;
   logic dataLine0In, dataLine1In, dataLine0Out, dataLine0Oe;
   logic dataLine1Out, dataLine1Oe, dataLine2Out, dataLine2Oe;
   logic dataLine3Out, dataLine3Oe, dataLine2In, dataLine3In;
   logic quadEnableBit, pinFunctionSelect;
   logic quadCommandMode, driveDir;
   sfpf_pkg::sfpf_width_e busWidth;
   logic [7:0] txUnit, rxUnit, rxSeen = 8'h00, txSeen = 8'h00;
   logic txTaken, rxValid, writeProtectN, selected, paused, inReset;
   logic [`SFPF_ADDR_W-1:0] byteAddr;
   int txCnt = 0;
   logic [`SFPF_SECT_W-1:0] sectorIdx;
   logic [`SFPF_BLK32_W-1:0] block32Idx;
   logic [`SFPF_BLK64_W-1:0] block64Idx;
   int error_cnt = 0, num_checks = 0, rxCnt = 0;
   assign dataLine0In = dataLine0Oe ? dataLine0Out : mData0;
   assign dataLine1In = dataLine1Oe ? dataLine1Out : 1'h1;
   initial forever #10 sys_clk = ~sys_clk;
   sfpf_front_end #(.UNIT_W(8)) DUT (.sys_clk, .rstn, .chipSelN,
      .serialClk, .dataLine0In, .dataLine0Out, .dataLine0Oe, .dataLine1In,
      .dataLine1Out, .dataLine1Oe, .dataLine2In, .dataLine2Out,
      .dataLine2Oe, .dataLine3In, .dataLine3Out, .dataLine3Oe,
      .quadEnableBit, .pinFunctionSelect, .quadCommandMode, .busWidth,
      .driveDir, .txUnit, .txTaken, .rxUnit, .rxValid, .writeProtectN,
      .selected, .paused, .inReset, .byteAddr, .sectorIdx, .block32Idx,
      .block64Idx);
   sfpf_spi_master bfm (.sys_clk, .chipSelN, .serialClk, .dataOut(mData0));
   always @(posedge sys_clk) if (rxValid === 1'h1) begin
      rxSeen <= rxUnit;
      rxCnt <= rxCnt + 1;
   end
   always @(posedge sys_clk) if (txTaken === 1'h1) txCnt <= txCnt + 1;
   // master samples the output on rising link clock edges
   always @(posedge serialClk) if (dataLine1Oe === 1'h1)
      txSeen <= {txSeen[6:0], dataLine1Out};
   task automatic test_tx(input logic [7:0] val);
      int n0;
      n0 = txCnt;
      driveDir <= 1'h1;
      txUnit <= val;
      bfm.open_frame(1'h1);
      bfm.put_bits(4'h0);
      bfm.put_bits(4'h0);
      bfm.close_frame();
      driveDir <= 1'h0;
      check(txSeen, val);
      check(txCnt - n0, 24'h000001);
   endtask
   task automatic check(input logic [23:0] got, input logic [23:0] exp);
      num_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: %h vs %h", $time, got, exp);
      end
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic test_rx(input logic mode3, input logic [7:0] val);
      int n0;
      n0 = rxCnt;
      bfm.open_frame(mode3);
      bfm.put_bits(val[7:4]);
      bfm.put_bits(val[3:0]);
      bfm.close_frame();
      bfm.put_bits(~val[7:4]);
      bfm.close_frame();
      check(rxSeen, val);
      check(rxCnt - n0, 24'h000001);
   endtask
   task automatic test_pause(input logic [7:0] val);
      bfm.open_frame(1'h0);
      bfm.put_bits(val[7:4]);
      dataLine3In <= 1'h0;
      bfm.wait_cyc(8);
      check({paused, dataLine1Oe}, 24'h000002);
      bfm.put_bits(~val[3:0]);
      dataLine3In <= 1'h1;
      bfm.wait_cyc(8);
      bfm.put_bits(val[3:0]);
      bfm.close_frame();
      check(rxSeen, val);
   endtask
   // no internal write is pending when reset is pulled
   task automatic test_reset();
      pinFunctionSelect <= 1'h1;
      dataLine3In <= 1'h0;
      bfm.wait_cyc(8);
      check({inReset, dataLine0Oe, dataLine1Oe}, 24'h000004);
      dataLine3In <= 1'h1;
      bfm.wait_cyc(8);
      check(inReset, 24'h000000);
      pinFunctionSelect <= 1'h0;
   endtask
   task automatic test_qe();
      quadEnableBit <= 1'h1;
      pinFunctionSelect <= 1'h1;
      dataLine2In <= 1'h0;
      dataLine3In <= 1'h0;
      bfm.wait_cyc(8);
      check({inReset, paused, writeProtectN}, 24'h000001);
      quadEnableBit <= 1'h0;
      bfm.wait_cyc(8);
      check({inReset, writeProtectN}, 24'h000002);
      dataLine2In <= 1'h1;
      dataLine3In <= 1'h1;
      pinFunctionSelect <= 1'h0;
      bfm.wait_cyc(8);
   endtask
   task automatic test_addr();
      logic [23:0] tbl [5] = '{24'h000000, 24'h00FFFF, 24'h010000,
         24'h07F123, 24'hFFF000};
      logic [23:0] s;
      foreach (tbl[i]) begin
         byteAddr <= tbl[i];
         bfm.wait_cyc(2);
         s = (tbl[i] / 24'h001000) % 24'h000100;
         check(sectorIdx, s);
         check(block32Idx, s / 24'h000008);
         check(block64Idx, s / 24'h000010);
      end
   endtask
   initial begin
      rstn <= 1'h0;
      dataLine2In <= 1'h1;
      dataLine3In <= 1'h1;
      quadEnableBit <= 1'h0;
      pinFunctionSelect <= 1'h0;
      quadCommandMode <= 1'h0;
      driveDir <= 1'h0;
      busWidth <= sfpf_pkg::SFPF_SINGLE;
      txUnit <= 8'h00;
      byteAddr <= 24'h000000;
      repeat (6) @(posedge sys_clk);
      rstn <= 1'h1;
      bfm.wait_cyc(4);
      test_tx(8'h96);
      test_rx(1'h0, 8'hA5);
      test_rx(1'h1, 8'h3C);
      test_pause(8'hC3);
      test_reset();
      test_rx(1'h1, 8'h81);
      test_qe();
      test_addr();
      complete_run();
   end
   initial begin
      repeat (50000) @(posedge sys_clk);
      error_cnt++;
      complete_run();
   end
endmodule // sfpf_front_end_tb
bind sfpf_front_end sfpf_front_end_sva u_sva (.sys_clk, .rstn,
   .dataLine0Oe, .dataLine1Oe, .dataLine2Oe, .dataLine3Oe, .dataLine3In,
   .quadEnableBit, .pinFunctionSelect, .writeProtectN, .selected, .paused,
   .inReset, .byteAddr, .sectorIdx, .block32Idx, .block64Idx);
`default_nettype wire
